// [rtl/hai_core.sv]
/*
 Hall angle interval processor: filtering, offset, interval with
 hysteresis, high-accuracy and stationary flags, auto tuning of the
 plate settings and interval centering, with an APB register file.
 Assumes the sampling front end and touch logic run on pclk and give
 one-cycle strobes; quadrature pin timing lives outside.
*/
// The address map and register access over APB are this design's own decisions.
// Function
// R1: Raw absolute angle is unsigned 16 bits spanning one full turn.
// R2: Processed angle is the filtered angle plus the angular offset.
// R3: Interval index is processed angle times count over 65536.
// R4: Each plate pair of samples combines into a harmonic-mean reference.
// R5: Tuning moves plate settings until references sit between the targets.
// R6: Tuning runs at start-up, later only if enabled, stationary, off band.
// R7: Slow filter by default, fast when fast/slow gap exceeds threshold.
// R8: Each interval change gives a quadrature event, and a window if streaming.
// R9: Hysteresis at interval boundaries stops toggling on small jitter.
// R10: High accuracy on interval change, forced freewheel, or filter gap.
// R11: High-accuracy flag holds for its timeout; its exit may center.
// R12: Stationary flag after the stationary timeout without movement.
// R13: Centering moves the offset so the angle sits mid-interval.
// R14: Center-now puts the processed angle mid first interval.
// R15: Host should issue center-now after changing the interval count.
// R16: Four auto-zero modes; off never centers automatically.
// R17: Stationary mode adjusts once per high-accuracy exit, beta 0 exact.
// R18: Continuous mode pulls toward the interval centre all the time.
// R19: Release mode also centers on every touch release.
// R20: Offset comes from manual value, start-up capture, or auto centering.
// R21: Interval change is the new index against the held index.
module hai_core (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input hai_pkg::hai_sample_t smp,
  input logic smp_valid,
  input logic freewheel,
  input logic touch_release,
  output hai_pkg::hai_evt_t evt,
  output logic high_accuracy,
  output logic stationary,
  output logic tuning,
  output logic [3:0][7:0] plate_set
);
  import hai_pkg::*;

  function automatic logic [15:0] bstep(input logic [15:0] y,
      input logic [15:0] x, input logic [3:0] b);
    logic signed [15:0] d;
    d = $signed(x - y);
    bstep = y + 16'(d >>> b);
  endfunction

  function automatic logic [15:0] cabs(input logic [15:0] a,
      input logic [15:0] b);
    logic signed [15:0] d;
    d = $signed(a - b);
    cabs = (d < 0) ? 16'(-d) : 16'(d);
  endfunction

  // 2ab/(a+b), saturated to 16 bits
  function automatic logic [15:0] hmean(input logic [15:0] a,
      input logic [15:0] b);
    logic [32:0] n;
    logic [32:0] q;
    logic [16:0] s;
    n = {({16'h0, a} * {16'h0, b}), 1'b0};
    s = {1'b0, a} + {1'b0, b};
    q = (s == 17'h0) ? 33'h0 : n / {16'h0, s};
    hmean = (q > 33'h0ffff) ? 16'hffff : q[15:0];
  endfunction

  function automatic logic [7:0] inc(input logic [7:0] i,
      input logic [7:0] n);
    inc = (i + 8'h1 >= n) ? 8'h0 : i + 8'h1;
  endfunction

  logic [31:0] ctrl_q, ivl_q, filt_q, tmo_q, tgt_q, prdata_q;
  logic [7:0] band_q, cur_q;
  logic [15:0] man_q, abs_q, slow_q, fast_q, ofs_q, ofs_d;
  logic [15:0] ha_cnt_q, ha_cnt_d, st_cnt_q, st_cnt_d;
  logic [3:0][15:0] ref_q;
  logic [3:0][7:0] set_q;
  logic first_q, tick_q, ha_q, st_q, cn_q;
  hai_tune_t tune_q, tune_d;
  hai_evt_t evt_q;

  // Bus decode
  wire setup = psel & ~penable;
  // Unaligned or past the last register: error, write dropped
  wire hit = (paddr[1:0] == 2'b00) && (paddr <= A_PLATE);
  wire wr_en = psel & penable & pwrite & hit;
  wire rtune = ctrl_q[C_RTUNE];
  wire stream = ctrl_q[C_STREAM];
  wire force_ha = ctrl_q[C_FORCE];
  wire st_ctr = ctrl_q[C_STCTR];
  wire hai_az_t az = hai_az_t'(ctrl_q[C_AZ +: 2]);
  wire hai_src_t src = hai_src_t'(ctrl_q[C_SRC +: 2]);
  wire [7:0] num = ivl_q[I_NUM +: 8];
  wire [7:0] nsafe = (num == 8'h0) ? 8'h1 : num;
  wire [15:0] hys = ivl_q[I_HYS +: 16];
  wire [3:0] sb = filt_q[F_SB +: 4];
  wire [3:0] fb = filt_q[F_FB +: 4];
  wire [15:0] thr = filt_q[F_THR +: 16];
  wire [3:0] azb = filt_q[F_AZB +: 4];
  wire [15:0] ha_tmo = tmo_q[T_HA +: 16];
  wire [15:0] st_tmo = tmo_q[T_ST +: 16];
  wire [15:0] tmin = tgt_q[G_MIN +: 16];
  wire [15:0] tmax = tgt_q[G_MAX +: 16];
  wire cn_set = wr_en && paddr == A_CTRL && pwdata[C_CENTER];

  // Slow filter unless the fast one has pulled away [R7]
  wire use_fast = cabs(fast_q, slow_q) > thr;
  wire [15:0] filt = use_fast ? fast_q : slow_q;
  wire [15:0] proc = filt + ofs_q; // [R2]

  // Interval index and position inside it [R3]
  wire [23:0] prod = 24'(proc * num);
  wire [7:0] idx_raw = prod[23:16];
  wire [15:0] frac = prod[15:0];
  wire up1 = idx_raw == inc(cur_q, nsafe);
  wire dn1 = inc(idx_raw, nsafe) == cur_q;
  // A neighbour is taken only past the hysteresis band [R9]
  wire pass = up1 ? (frac >= hys) : dn1 ? (frac <= ~hys) : 1'b1;
  wire accept = tick_q && (idx_raw != cur_q) && pass; // [R21]
  wire dir_up = up1 | (~dn1 & (idx_raw > cur_q));

  // High-accuracy triggers and exit [R10] [R11]
  wire trig = tick_q & (accept | (freewheel & force_ha) | use_fast);
  assign ha_cnt_d = trig ? ha_tmo :
      (tick_q && ha_cnt_q != 16'h0) ? ha_cnt_q - 16'h1 : ha_cnt_q;
  wire ha_exit = tick_q & ~trig & (ha_cnt_q == 16'h1);

  // Stationary detection on raw angle movement [R12]
  wire move = smp_valid && cabs(smp.angle, abs_q) > MOVE_THR;
  assign st_cnt_d = ~smp_valid ? st_cnt_q : move ? 16'h0 :
      (st_cnt_q < st_tmo) ? st_cnt_q + 16'h1 : st_cnt_q;
  wire st_d = (st_cnt_d >= st_tmo) && !move;
  wire st_rise = st_d & ~st_q;

  // Centering targets [R13]
  wire [16:0] isize = 17'h10000 / {9'h0, nsafe};
  wire [15:0] half = isize[16:1];
  wire [15:0] center = 16'(cur_q * isize) + half;
  wire signed [15:0] cdelta = $signed(center - proc);
  wire [15:0] az_ofs = ofs_q + 16'(cdelta >>> azb); // [R17] [R18]
  wire [15:0] cn_ofs = ofs_q + half - proc; // [R14]
  // Auto events; off mode never reaches here [R16]
  wire az_evt = (az != AZ_OFF) & (ha_exit | (st_rise & st_ctr)) |
      (az == AZ_REL) & touch_release; // [R19]
  wire az_go = ((az == AZ_CONT) & tick_q) | az_evt; // [R18]
  wire man_wr = wr_en && paddr == A_MAN && src == SRC_MANUAL;
  wire start_cap = smp_valid & first_q & (src == SRC_STARTUP);
  // Offset source priority: manual, center-now, start-up, auto [R20]
  assign ofs_d = man_wr ? pwdata[15:0] : cn_q ? cn_ofs :
      start_cap ? 16'(16'h0 - smp.angle) : az_go ? az_ofs : ofs_q;

  // Tuning of the plate settings [R4] [R5] [R6]
  wire [15:0] tref = hmean(tmax, tmin);
  wire [7:0] bsafe = (band_q == 8'h0) ? 8'h1 : band_q;
  wire [15:0] span = 16'((tmax - tmin) / {8'h0, bsafe});
  logic [3:0] dev, upv, dnv;
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_plate
      assign dev[p] = ((ref_q[p] > tref) ? ref_q[p] - tref :
          tref - ref_q[p]) > span;
      // Higher setting is taken to raise the plate counts
      assign upv[p] = ref_q[p] < tmin && set_q[p] != 8'hff;
      assign dnv[p] = ref_q[p] > tmax && set_q[p] != 8'h00;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ref_q[p] <= 16'h0;
          set_q[p] <= PLATE_RST;
        end else begin
          if (smp_valid)
            ref_q[p] <= hmean(smp.cnt[p], smp.cnt_inv[p]); // [R4]
          if (tune_q == T_RUN && tick_q && upv[p])
            set_q[p] <= set_q[p] + 8'h1; // [R5]
          else if (tune_q == T_RUN && tick_q && dnv[p])
            set_q[p] <= set_q[p] - 8'h1; // [R5]
        end
      end
    end
  endgenerate

  // Stops when every plate is in range or pinned at its limit
  always_comb begin
    tune_d = tune_q;
    unique case (tune_q)
      T_IDLE: if (tick_q && rtune && st_q && |dev) tune_d = T_RUN; // [R6]
      T_RUN: if (tick_q && !(|(upv | dnv))) tune_d = T_IDLE;
    endcase
  end

  // Read mux
  wire [31:0] rd = (paddr == A_CTRL) ? ctrl_q :
      (paddr == A_IVL) ? ivl_q : (paddr == A_FILT) ? filt_q :
      (paddr == A_TMO) ? tmo_q : (paddr == A_TGT) ? tgt_q :
      (paddr == A_BAND) ? {24'h0, band_q} :
      (paddr == A_MAN) ? {16'h0, man_q} :
      (paddr == A_ANG) ? {proc, abs_q} :
      (paddr == A_STAT) ? {20'h0, tune_q, use_fast, st_q, ha_q, cur_q} :
      (paddr == A_OFS) ? {16'h0, ofs_q} : set_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      ivl_q <= IVL_RST;
      filt_q <= FILT_RST;
      tmo_q <= TMO_RST;
      tgt_q <= TGT_RST;
      band_q <= BAND_RST;
      man_q <= 16'h0;
      prdata_q <= 32'h0;
    end else begin
      if (setup)
        prdata_q <= hit ? rd : 32'h0;
      if (wr_en && paddr == A_CTRL)
        ctrl_q <= pwdata & CTRL_MASK;
      if (wr_en && paddr == A_IVL)
        ivl_q <= {8'h0, pwdata[23:0]};
      if (wr_en && paddr == A_FILT)
        filt_q <= {4'h0, pwdata[27:0]};
      if (wr_en && paddr == A_TMO)
        tmo_q <= pwdata;
      if (wr_en && paddr == A_TGT)
        tgt_q <= pwdata;
      if (wr_en && paddr == A_BAND)
        band_q <= pwdata[7:0];
      if (wr_en && paddr == A_MAN)
        man_q <= pwdata[15:0];
    end
  end

  // Sample path: raw angle and the two filters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abs_q <= 16'h0;
      slow_q <= 16'h0;
      fast_q <= 16'h0;
      first_q <= 1'b1;
      tick_q <= 1'b0;
    end else begin
      tick_q <= smp_valid;
      if (smp_valid) begin
        abs_q <= smp.angle; // [R1]
        first_q <= 1'b0;
        // Filters start on the first sample to avoid a ramp from zero
        slow_q <= first_q ? smp.angle : bstep(slow_q, smp.angle, sb);
        fast_q <= first_q ? smp.angle : bstep(fast_q, smp.angle, fb);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= 8'h0;
      evt_q <= '0;
      ha_cnt_q <= 16'h0;
      ha_q <= 1'b0;
      st_cnt_q <= 16'h0;
      st_q <= 1'b0;
      ofs_q <= 16'h0;
      cn_q <= 1'b0;
      tune_q <= T_RUN; // [R6]
    end else begin
      if (accept)
        cur_q <= idx_raw; // [R3]
      evt_q <= '{step: accept, up: dir_up, window: accept & stream}; // [R8]
      ha_cnt_q <= ha_cnt_d;
      ha_q <= ha_cnt_d != 16'h0; // [R11]
      st_cnt_q <= st_cnt_d;
      st_q <= st_d; // [R12]
      ofs_q <= ofs_d;
      cn_q <= cn_set; // [R14]
      tune_q <= tune_d;
    end
  end

  assign prdata = prdata_q;
  // Registers answer at once, so the access phase never stretches
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign evt = evt_q;
  assign high_accuracy = ha_q;
  assign stationary = st_q;
  assign tuning = tune_q == T_RUN;
  assign plate_set = set_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_abs;
    smp_valid |=> abs_q == $past(smp.angle);
  endproperty
  a_abs: assert property (p_abs) else $error("abs angle lost"); // [R1]

  property p_idx;
    accept |=> cur_q == $past(idx_raw) && evt_q.step;
  endproperty
  a_idx: assert property (p_idx) else $error("interval not taken"); // [R3]

  property p_win;
    evt_q.step |-> evt_q.window == $past(stream);
  endproperty
  a_win: assert property (p_win) else $error("window wrong"); // [R8]

  property p_hys;
    tick_q && up1 && frac < hys |=> $stable(cur_q);
  endproperty
  a_hys: assert property (p_hys) else $error("hysteresis ignored"); // [R9]

  property p_ha;
    tick_q && use_fast && ha_tmo != 16'h0 |=> ha_q [*1] ##1 1'b1;
  endproperty
  a_ha: assert property (p_ha) else $error("no high accuracy"); // [R10]

  property p_center;
    cn_q && !man_wr |=> proc == $past(half) + (filt - $past(filt));
  endproperty
  a_center: assert property (p_center) else $error("center-now off"); // [R14]

  property p_azoff;
    az == AZ_OFF && !man_wr && !cn_q && !start_cap |=> $stable(ofs_q);
  endproperty
  a_azoff: assert property (p_azoff) else $error("offset moved"); // [R16]

  property p_azstat;
    az == AZ_STAT && ha_exit && !man_wr && !cn_q && !start_cap
      |=> ofs_q == $past(az_ofs);
  endproperty
  a_azstat: assert property (p_azstat) else $error("no az step"); // [R17]

  property p_stat;
    st_q |-> st_cnt_q >= $past(st_tmo);
  endproperty
  a_stat: assert property (p_stat) else $error("early stationary"); // [R12]

  property p_tune;
    tune_q == T_IDLE && tick_q && !(rtune && st_q) |=> tune_q == T_IDLE;
  endproperty
  a_tune: assert property (p_tune) else $error("tuning started"); // [R6]

  property p_cap;
    start_cap && !man_wr && !cn_q |=> ofs_q == 16'(16'h0 - $past(smp.angle));
  endproperty
  a_cap: assert property (p_cap) else $error("no start-up offset"); // [R20]

  property p_hold;
    tune_q != T_RUN |=> $stable(set_q);
  endproperty
  a_hold: assert property (p_hold) else $error("plates moved"); // [R5]

  property p_rel;
    az == AZ_REL && touch_release && !man_wr && !cn_q && !start_cap
      |=> ofs_q == $past(az_ofs);
  endproperty
  a_rel: assert property (p_rel) else $error("no release step"); // [R19]

  property p_exit;
    ha_exit |=> !ha_q;
  endproperty
  a_exit: assert property (p_exit) else $error("accuracy held"); // [R11]

  c_step: cover property (evt_q.step ##1 !evt_q.step);
  c_exit: cover property (ha_exit && az == AZ_STAT);
  c_tune: cover property (tune_q == T_RUN ##1 tune_q == T_IDLE);
  c_rel: cover property (az == AZ_REL && touch_release);
  c_cap: cover property (start_cap);
endmodule

// [shared/hai_pkg.sv]
/*
 Package for the Hall angle interval processor: register map, field
 positions, reset values, modes and the carrier structs.
 Assumes one APB clock domain shared with the sampling front end.
*/
package hai_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IVL = 8'h04;
  localparam logic [7:0] A_FILT = 8'h08;
  localparam logic [7:0] A_TMO = 8'h0c;
  localparam logic [7:0] A_TGT = 8'h10;
  localparam logic [7:0] A_BAND = 8'h14;
  localparam logic [7:0] A_MAN = 8'h18;
  localparam logic [7:0] A_ANG = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_OFS = 8'h24;
  localparam logic [7:0] A_PLATE = 8'h28;
  localparam int C_RTUNE = 0;
  localparam int C_STREAM = 1;
  localparam int C_FORCE = 2;
  localparam int C_AZ = 3;
  localparam int C_CENTER = 5;
  localparam int C_SRC = 6;
  localparam int C_STCTR = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_01df;
  localparam int I_NUM = 0;
  localparam int I_HYS = 8;
  localparam int F_SB = 0;
  localparam int F_FB = 4;
  localparam int F_THR = 8;
  localparam int F_AZB = 24;
  localparam int T_HA = 0;
  localparam int T_ST = 16;
  localparam int G_MIN = 0;
  localparam int G_MAX = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] IVL_RST = 32'h0010_0018;
  localparam logic [31:0] FILT_RST = 32'h0302_0214;
  localparam logic [31:0] TMO_RST = 32'h0064_0028;
  localparam logic [31:0] TGT_RST = 32'h0600_0200;
  localparam logic [7:0] BAND_RST = 8'h10;
  localparam logic [7:0] PLATE_RST = 8'h80;
  localparam logic [15:0] MOVE_THR = 16'h0010;
  typedef enum logic [1:0] {
    AZ_OFF = 2'b00, AZ_STAT = 2'b01, AZ_CONT = 2'b10, AZ_REL = 2'b11
  } hai_az_t;
  typedef enum logic [1:0] {
    SRC_MANUAL = 2'b00, SRC_STARTUP = 2'b01, SRC_AUTO = 2'b10
  } hai_src_t;
  typedef enum logic {T_IDLE = 1'b0, T_RUN = 1'b1} hai_tune_t;
  typedef struct packed {
    logic [15:0] angle;
    logic [3:0][15:0] cnt;
    logic [3:0][15:0] cnt_inv;
  } hai_sample_t;
  typedef struct packed {
    logic step;
    logic up;
    logic window;
  } hai_evt_t;
endpackage

// [tb/hai_core_tb_top.sv]
/*
 Self-checking bench for the Hall angle interval processor.
 Assumes zero-wait APB and the sample front end model beside it.
*/
module hai_core_tb_top;
  import hai_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  hai_sample_t smp;
  hai_evt_t evt;
  logic smp_valid, freewheel, touch_release;
  logic high_accuracy, stationary, tuning, er, strm;
  logic [3:0][7:0] plate_set;
  logic [15:0] p1;
  int n_errors, checks_done, cyc;
  always #2.5 pclk = ~pclk;
  hai_core u_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp(smp),
    .smp_valid(smp_valid), .freewheel(freewheel),
    .touch_release(touch_release), .evt(evt),
    .high_accuracy(high_accuracy), .stationary(stationary),
    .tuning(tuning), .plate_set(plate_set));
  hai_fe_model u_fe(.pclk(pclk), .smp(smp), .smp_valid(smp_valid));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave stalls; only the bench timeout ends it
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic feed(input logic [15:0] a, input int n);
    repeat (n) u_fe.send(a);
    #1;
  endtask
  // Event is due two cycles after the sample and lasts one cycle
  task automatic stp(input logic [15:0] a, input logic s, input logic u);
    u_fe.send(a);
    @(posedge pclk);
    #1;
    chk(32'({evt.step, evt.window}), 32'({s, s & strm}));
    if (s) chk(32'(evt.up), 32'(u));
    @(posedge pclk);
    #1;
    chk(32'(evt.step), 32'h0);
  endtask
  task automatic t_regs;
    rdc(A_CTRL, CTRL_RST);
    rdc(A_IVL, IVL_RST);
    rdc(A_FILT, FILT_RST);
    rdc(A_TMO, TMO_RST);
    rdc(A_TGT, TGT_RST);
    rdc(A_BAND, 32'(BAND_RST));
    rdc(A_PLATE, 32'h8080_8080);
    apb(1'b0, 8'h2c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task automatic t_tune;
    chk(32'(tuning), 32'h1);
    for (int i = 0; i < 100 && tuning !== 1'b0; i++) u_fe.send(16'h1000);
    #1;
    chk(32'(tuning), 32'h0);
    chk(plate_set, 32'h8080_8080);
  endtask
  task automatic t_center;
    wr(A_FILT, 32'h0002_0000);
    wr(A_IVL, 32'h0010_0004);
    wr(A_TMO, 32'h0003_0002);
    wr(A_CTRL, 32'h80);
    feed(16'h7777, 2);
    wr(A_CTRL, 32'ha0);
    feed(16'h7777, 2);
    rdc(A_ANG, 32'h2000_7777);
    rdc(A_CTRL, 32'h80);
    strm = 1'b1;
    wr(A_CTRL, 32'h02);
    wr(A_MAN, 32'h0);
    rdc(A_OFS, 32'h0);
  endtask
  task automatic t_steps;
    feed(16'h2000, 2);
    stp(16'h6000, 1'b1, 1'b1);
    chk(32'({high_accuracy, stationary}), 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[7:0]), 32'h1);
    stp(16'h2000, 1'b1, 1'b0);
    stp(16'h3ff8, 1'b0, 1'b0);
    stp(16'h4002, 1'b0, 1'b0);
    stp(16'h4800, 1'b1, 1'b1);
    strm = 1'b0;
    wr(A_CTRL, 32'h0);
    stp(16'h2000, 1'b1, 1'b0);
    feed(16'h2000, 8);
    chk(32'({high_accuracy, stationary}), 32'h1);
  endtask
  task automatic t_fast;
    wr(A_FILT, 32'h0002_0004);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[10]), 32'h0);
    feed(16'ha000, 1);
    // The flag follows on the tick edge after the sample edge
    @(posedge pclk);
    #1;
    chk(32'(high_accuracy), 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[10]), 32'h1);
    wr(A_FILT, 32'h0002_0000);
    feed(16'ha000, 8);
    wr(A_CTRL, 32'h04);
    @(posedge pclk) freewheel <= 1'b1;
    feed(16'ha000, 1);
    @(posedge pclk);
    #1;
    chk(32'(high_accuracy), 32'h1);
    @(posedge pclk) freewheel <= 1'b0;
  endtask
  task automatic t_az;
    wr(A_CTRL, 32'h80);
    feed(16'h5000, 10);
    rdc(A_OFS, 32'h0);
    wr(A_CTRL, 32'h88);
    feed(16'h9000, 10);
    rdc(A_ANG, 32'ha000_9000);
    wr(A_CTRL, 32'h98);
    feed(16'h9400, 4);
    rdc(A_ANG, 32'ha400_9400);
    @(posedge pclk) touch_release <= 1'b1;
    @(posedge pclk) touch_release <= 1'b0;
    feed(16'h9400, 2);
    rdc(A_ANG, 32'ha000_9400);
    wr(A_FILT, 32'h0202_0000);
    wr(A_CTRL, 32'h90);
    feed(16'h9800, 2);
    apb(1'b0, A_ANG, 32'h0);
    p1 = rd[31:16];
    feed(16'h9800, 30);
    apb(1'b0, A_ANG, 32'h0);
    chk(32'(rd[31:16] < p1 && rd[31:16] >= 16'ha000), 32'h1);
  endtask
  // Mid-run reset: start-up capture, then runtime tuning on weak plates
  task automatic t_rst;
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'({tuning, high_accuracy, stationary}), 32'h4);
    wr(A_CTRL, 32'h41);
    wr(A_TMO, 32'h0003_0002);
    feed(16'h1234, 2);
    rdc(A_OFS, 32'h0000_edcc);
    u_fe.cnt = 16'h0100;
    feed(16'h1234, 4);
    rdc(A_PLATE, 32'h8282_8282);
    chk(32'(tuning), 32'h1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run is a few hundred cycles; the ceiling only cuts a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    freewheel = 1'b0;
    touch_release = 1'b0;
    strm = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tune;
    t_center;
    t_steps;
    t_fast;
    t_az;
    t_rst;
    report_and_stop;
  end
endmodule

// [tb/hai_fe_model.sv]
/*
 Sampling front end model: sends one angle sample with plate counts that
 the bench may lower to imitate a weak magnet.
 Assumes pclk domain; the bench calls send() from its own process.
*/
module hai_fe_model
  import hai_pkg::*;
(
  input wire logic pclk,
  output hai_pkg::hai_sample_t smp,
  output logic smp_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts sit at the target centre so start-up tuning has no work
  logic [15:0] cnt = 16'h0300;
  initial begin
    smp = '0;
    smp_valid = 1'b0;
  end
  // Normal and inverted count for each of four plates
  task automatic send(input logic [15:0] a);
    @(posedge pclk);
    smp_valid <= 1'b1;
    smp <= {a, {8{cnt}}};
    @(posedge pclk);
    smp_valid <= 1'b0;
    // Stale data is inverted so nothing can lean on a held value
    smp <= ~{a, {8{cnt}}};
  endtask
endmodule
